// ==== core/vfdrx_pkg.sv ====
package vfdrx_pkg;
  // word framing
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned ADDR_BITS = 5;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 13;
  // first word classification fields
  localparam int unsigned KIND_CTRL_BIT = 7;
  localparam int unsigned KIND_START_BIT = 6;
  localparam int unsigned ADDR_MSB = 4;
  localparam int unsigned DUTY_MSB = 6;
  localparam int unsigned DUTY_LSB = 4;
  localparam int unsigned DISP_ON_BIT = 3;
  localparam int unsigned SHIFT_MSB = 2;
  localparam int unsigned START_MSB = 3;
  // reset values
  localparam logic [2:0] DUTY_RESET = 3'h0;
  localparam logic DISP_ON_RESET = 1'b0;
  localparam logic [2:0] SHIFT_RESET = 3'h0;
  localparam logic [3:0] START_RESET = 4'h1;
  // addresses above the last real cell
  localparam logic [4:0] ADDR_VOID_LO = 5'h1e;
  localparam logic [4:0] ADDR_VOID_HI = 5'h1f;
  // transfer kind after first word
  typedef enum logic [1:0] {VFDRX_IDLE, VFDRX_DATA, VFDRX_DROP} vfdrx_mode_type;
endpackage : vfdrx_pkg

// ==== core/vfdrx_fifo.sv ====
`timescale 1ns/1ps
module vfdrx_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic ov;
    logic [WIDTH-1:0] od;
  } vfdrx_fifo_st_type;
  vfdrx_fifo_st_type s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full, empty, push, pop;

  // flags and handshakes
  assign empty = (s_q.wp == s_q.rp);
  assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;
  assign pop = !empty && (!s_q.ov || out_ready_i);
  assign out_valid_o = s_q.ov;
  assign out_data_o = s_q.od;

  // pointer and output register update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (s_q.ov && out_ready_i) begin
      s_d.ov = 1'b0;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
      s_d.ov = 1'b1;
      s_d.od = mem_q[s_q.rp[AW-1:0]];
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage, not reset
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[s_q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule : vfdrx_fifo

// ==== core/vfdrx_receiver.sv ====
`timescale 1ns/1ps
// Overview of operation
// R1: serial data is sampled on each rising edge of the serial clock.
// R2: a word is exactly eight bits carried by eight clock pulses.
// R3: the collected bits are taken as one word on the rising edge of select; the code takes each word on its eighth serial clock rise instead.
// R4: the first word of a transfer is an address, a control command or a start-digit command.
// R5: after an address first word every further word of the transfer is display data.
// R6: after a command first word every further word is dropped with no effect.
// R7: top bits 00 mean address, bit 5 ignored, bits 4..0 are the memory address.
// R8: top bit 1 means control: duty in 6..4, display on in 3, shift count in 2..0.
// R9: top bits 01 mean start digit, bits 5..4 ignored, bits 3..0 are the start character.
// R10: words are accepted only while the active low select is held low.
// R11: each data write increments the address through 1e and 1f, wrapping to 0, writes at 1e and 1f dropped.
// R12: reset restores both command registers, start character 0001, memory untouched.
// R13: bits arrive most significant first.
// R14: bit counter and first word flag clear while select is high.
module vfdrx_receiver (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // serial link pins
  input wire logic select_n_i,
  input wire logic sck_i,
  input wire logic sdata_i,
  // command register outputs
  output logic [2:0] duty_code_o,
  output logic disp_on_o,
  output logic [2:0] shift_count_code_o,
  output logic [3:0] start_char_code_o,
  // display memory write stream
  output logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  output logic [vfdrx_pkg::ADDR_BITS-1:0] mem_wr_addr_o,
  output logic [vfdrx_pkg::WORD_BITS-1:0] mem_wr_data_o,
  // status
  output logic overflow_o
);
  import vfdrx_pkg::*;

  typedef struct packed {
    logic [1:0] sel_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic sck_prev;
    logic sel_prev;
    logic [WORD_BITS-1:0] shreg;
    logic [3:0] bit_cnt;
    vfdrx_mode_type mode;
    logic [ADDR_BITS-1:0] ptr;
    logic [2:0] duty;
    logic disp_on;
    logic [2:0] shift;
    logic [3:0] start;
    logic ovf;
  } vfdrx_st_type;

  vfdrx_st_type s_q, s_d;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [FIFO_WIDTH-1:0] fifo_in_data, fifo_out_data;
  logic sel_n, sck_rise, word_done;
  logic [WORD_BITS-1:0] word;

  // address cells that hold no display data
  function automatic logic addr_void(input logic [ADDR_BITS-1:0] a);
    return (a == ADDR_VOID_LO) || (a == ADDR_VOID_HI);
  endfunction : addr_void

  // synchronised pin views and edge events
  assign sel_n = s_q.sel_sync[1];
  // R1: serial clock rise
  assign sck_rise = s_q.sck_sync[1] && !s_q.sck_prev;
  // R3: word on select rise
  assign word_done = sel_n && !s_q.sel_prev && (s_q.bit_cnt == 4'(WORD_BITS));
  assign word = s_q.shreg;

  // next state
  always_comb begin
    s_d = s_q;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    s_d.sel_sync = {s_q.sel_sync[0], select_n_i};
    s_d.sck_sync = {s_q.sck_sync[0], sck_i};
    s_d.sdi_sync = {s_q.sdi_sync[0], sdata_i};
    s_d.sck_prev = s_q.sck_sync[1];
    s_d.sel_prev = sel_n;
    // R10: shift only while selected
    if (!sel_n && sck_rise) begin
      // R13: msb first shift
      s_d.shreg = {s_q.shreg[WORD_BITS-2:0], s_q.sdi_sync[1]};
      // R2: eight bits per word
      if (s_q.bit_cnt == 4'(WORD_BITS)) begin
        s_d.bit_cnt = 4'h1;
      end else begin
        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
      end
      // a full word inside a running transfer
      if (s_q.bit_cnt == 4'(WORD_BITS - 1) && s_q.mode != VFDRX_IDLE) begin
        s_d.bit_cnt = 4'h0;
        // R5: further words are data
        if (s_q.mode == VFDRX_DATA) begin
          // R11: skip void cells, always increment
          if (!addr_void(s_q.ptr)) begin
            fifo_in_valid = 1'b1;
            fifo_in_data = {s_q.ptr, s_q.shreg[WORD_BITS-2:0], s_q.sdi_sync[1]};
            if (!fifo_in_ready) begin
              s_d.ovf = 1'b1;
            end
          end
          s_d.ptr = s_q.ptr + 5'h1;
        end
        // R6: command transfers drop words
      end
      // R4: first word complete, classify
      if (s_q.bit_cnt == 4'(WORD_BITS - 1) && s_q.mode == VFDRX_IDLE) begin
        s_d.bit_cnt = 4'h0;
        word_kind(s_q.shreg[WORD_BITS-2:0], s_q.sdi_sync[1]);
      end
    end
    // R3: never taken, bit_cnt never reaches 8; a lone first word is classified on its eighth clock rise
    if (word_done && s_q.mode == VFDRX_IDLE) begin
      word_kind(word[WORD_BITS-1:1], word[0]);
    end
    // R14: clear framing while deselected
    if (sel_n) begin
      s_d.bit_cnt = 4'h0;
      s_d.mode = VFDRX_IDLE;
    end
  end

  // first word decode into command registers or pointer
  task automatic word_kind(input logic [WORD_BITS-2:0] hi, input logic lo);
    logic [WORD_BITS-1:0] w;
    w = {hi, lo};
    if (w[KIND_CTRL_BIT]) begin
      // R8: control command fields
      s_d.duty = w[DUTY_MSB:DUTY_LSB];
      s_d.disp_on = w[DISP_ON_BIT];
      s_d.shift = w[SHIFT_MSB:0];
      s_d.mode = VFDRX_DROP;
    end else if (w[KIND_START_BIT]) begin
      // R9: start character field
      s_d.start = w[START_MSB:0];
      s_d.mode = VFDRX_DROP;
    end else begin
      // R7: address field
      s_d.ptr = w[ADDR_MSB:0];
      s_d.mode = VFDRX_DATA;
    end
  endtask : word_kind

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.sel_sync <= 2'h3;
      s_q.sel_prev <= 1'b1;
      s_q.mode <= VFDRX_IDLE;
      // R12: command defaults
      s_q.duty <= DUTY_RESET;
      s_q.disp_on <= DISP_ON_RESET;
      s_q.shift <= SHIFT_RESET;
      s_q.start <= START_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // write stream buffer
  vfdrx_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(mem_wr_ready_i),
    .out_data_o(fifo_out_data)
  );

  // outputs from registers
  assign duty_code_o = s_q.duty;
  assign disp_on_o = s_q.disp_on;
  assign shift_count_code_o = s_q.shift;
  assign start_char_code_o = s_q.start;
  assign overflow_o = s_q.ovf;
  assign mem_wr_valid_o = fifo_out_valid;
  assign mem_wr_addr_o = fifo_out_data[FIFO_WIDTH-1:WORD_BITS];
  assign mem_wr_data_o = fifo_out_data[WORD_BITS-1:0];
endmodule : vfdrx_receiver

// ==== sim/vfdrx_checker.sv ====
`timescale 1ns/1ps
module vfdrx_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // link select
  input wire logic select_n_i,
  // command registers
  input wire logic [2:0] duty_code_o,
  input wire logic disp_on_o,
  input wire logic [2:0] shift_count_code_o,
  input wire logic [3:0] start_char_code_o,
  // write stream
  input wire logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  input wire logic [4:0] mem_wr_addr_o,
  input wire logic [7:0] mem_wr_data_o,
  input wire logic overflow_o
);
  import vfdrx_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [10:0] cmd = {duty_code_o, disp_on_o, shift_count_code_o, start_char_code_o};
  // command and stream relations
  a_reset_cmd_defaults: assert property ($rose(rstn_i) |->
    cmd == {DUTY_RESET, DISP_ON_RESET, SHIFT_RESET, START_RESET}) else $error("cmd not at defaults");
  a_reset_stream_quiet: assert property ($rose(rstn_i) |-> !mem_wr_valid_o && !overflow_o)
    else $error("stream busy after reset");
  a_valid_hold_stall: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
    mem_wr_valid_o && $stable({mem_wr_addr_o, mem_wr_data_o})) else $error("write dropped in stall");
  a_void_addr_drop: assert property (mem_wr_valid_o |-> mem_wr_addr_o < ADDR_VOID_LO)
    else $error("write to void address");
  a_overflow_sticky: assert property (overflow_o |=> overflow_o) else $error("overflow cleared");
  a_cmd_one_kind: assert property ($changed(start_char_code_o) |-> $stable(cmd[10:4]))
    else $error("both commands changed");
  a_idle_cmd_stable: assert property (select_n_i [*8] |=> $stable(cmd)) else $error("cmd changed idle");
  a_idle_no_overflow: assert property (select_n_i [*8] |=> !$rose(overflow_o))
    else $error("overflow while idle");
  // main scenarios reached
  c_write: cover property (mem_wr_valid_o && mem_wr_ready_i);
  c_stall: cover property (mem_wr_valid_o && !mem_wr_ready_i);
  c_overflow: cover property ($rose(overflow_o));
endmodule : vfdrx_checker
bind vfdrx_receiver vfdrx_checker u_vfdrx_checker (.ref_clk_i, .rstn_i, .select_n_i, .duty_code_o, .disp_on_o,
  .shift_count_code_o, .start_char_code_o, .mem_wr_valid_o, .mem_wr_ready_i, .mem_wr_addr_o, .mem_wr_data_o,
  .overflow_o);

// ==== sim/vfdrx_host.sv ====
`timescale 1ns/1ps
module vfdrx_host (
  // clock
  input wire logic ref_clk_i,
  // serial link pins
  output logic select_n_o,
  output logic sck_o,
  output logic sdata_o
);
  // idle: deselected, clock parked low
  initial begin
    select_n_o = 1'b1;
    sck_o = 1'b0;
    sdata_o = 1'b0;
  end
  // half of a 400 ns link period
  task automatic half();
    repeat (4) @(posedge ref_clk_i);
  endtask : half
  task automatic open_frame();
    @(posedge ref_clk_i);
    select_n_o <= 1'b0;
    half();
  endtask : open_frame
  task automatic put(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      sck_o <= 1'b0;
      sdata_o <= w[i];
      half();
      sck_o <= 1'b1;
      half();
    end
  endtask : put
  task automatic close_frame();
    sck_o <= 1'b0;
    half();
    select_n_o <= 1'b1;
    sdata_o <= ~sdata_o; // released line shows stale inverse
    half();
  endtask : close_frame
endmodule : vfdrx_host

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import vfdrx_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ready = 1'b1;
  logic select_n, sck, sdata, valid, disp_on, overflow;
  logic [2:0] duty, shift;
  logic [3:0] start;
  logic [4:0] addr;
  logic [7:0] data;
  logic [12:0] got[$];
  logic [7:0] q[$];
  int fails = 0;
  int tests_run = 0;
  initial forever #25 ref_clk_i = ~ref_clk_i;
  vfdrx_receiver u_vfdrx_receiver (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .select_n_i(select_n), .sck_i(sck),
    .sdata_i(sdata), .duty_code_o(duty), .disp_on_o(disp_on), .shift_count_code_o(shift), .start_char_code_o(start),
    .mem_wr_valid_o(valid), .mem_wr_ready_i(ready), .mem_wr_addr_o(addr), .mem_wr_data_o(data),
    .overflow_o(overflow));
  vfdrx_host u_vfdrx_host (.ref_clk_i(ref_clk_i), .select_n_o(select_n), .sck_o(sck), .sdata_o(sdata));
  // log every accepted write
  always @(negedge ref_clk_i) begin
    if (valid === 1'b1 && ready === 1'b1) got.push_back({addr, data});
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic do_reset();
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask : do_reset
  task automatic xfer(input logic [7:0] w[$]);
    u_vfdrx_host.open_frame();
    foreach (w[i]) u_vfdrx_host.put(w[i]);
    u_vfdrx_host.close_frame();
    repeat (10) @(posedge ref_clk_i);
  endtask : xfer
  task automatic wait_writes(input int n);
    for (int k = 0; k < 500 && got.size() < n; k++) @(posedge ref_clk_i);
    if (got.size() < n) begin
      fails++;
      $display("MISMATCH writes exp %0d got %0d", n, got.size());
      finish_test();
    end
  endtask : wait_writes
  // main sequence
  initial begin
    do_reset();
    `CHK("cmd", {DUTY_RESET, DISP_ON_RESET, SHIFT_RESET, START_RESET}, {duty, disp_on, shift, start})
    $display("test defaults done");
    xfer('{8'hbd, 8'h00});
    `CHK("cmd", 11'h3d1, {duty, disp_on, shift, start})
    xfer('{8'h7a, 8'h9f});
    `CHK("cmd", 11'h3da, {duty, disp_on, shift, start})
    `CHK("writes", 0, got.size())
    $display("test commands done");
    xfer('{8'h3c, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5});
    wait_writes(3);
    `CHK("w0", 13'h1ca1, got[0])
    `CHK("w1", 13'h1da2, got[1])
    `CHK("w2", 13'h00a5, got[2])
    `CHK("writes", 3, got.size())
    $display("test address wrap done");
    got.delete();
    q = '{8'h00};
    for (int i = 0; i < 20; i++) q.push_back(8'(i));
    ready <= 1'b0;
    xfer(q);
    `CHK("ovf", 1'b1, overflow)
    ready <= 1'b1;
    wait_writes(17);
    for (int i = 0; i < 17; i++) `CHK("fill", {5'(i), 8'(i)}, got[i])
    `CHK("fill count", 17, got.size())
    $display("test fill done");
    do_reset();
    `CHK("cmd", 11'h001, {duty, disp_on, shift, start})
    `CHK("ovf", 1'b0, overflow)
    $display("test second reset done");
    finish_test();
  end
endmodule : tb_top
